// ### shared/tmr_consts.svh
// Purpose: Offsets, field positions and reset values of the timer channel
// Assumes: Byte offsets on the plain register port, 16-bit data
// Notes: Definitions only
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define ADDR_W 28
`define DATA_W 16
`define OFS_CTL0 28'hffff640
`define OFS_IOC0 28'hffff642
`define OFS_IOC1 28'hffff643
`define OFS_IOC2 28'hffff644
`define OFS_OPT0 28'hffff645
`define OFS_CCR0 28'hffff646
`define OFS_CCR1 28'hffff648
`define OFS_CNT 28'hffff64e
`define OFS_CTL1 28'hffff661

`define BIT_RUN 7
`define BIT_TUNE 7
`define BIT_STRG 6
`define BIT_EEE 5
`define BIT_OL1 3
`define BIT_OE1 2
`define BIT_OL0 1
`define BIT_OE0 0
`define BIT_CCS1 5
`define BIT_CCS0 4
`define BIT_OVF 0

`define RST_REG8 8'h00
`define RST_CCR 16'h0000
`define CNT_IDLE 16'hffff
`define CNT_IDLE_RD 16'h0000
`define CNT_ONE 16'h0001
`define PRE_W 7

`endif

// ### shared/tmr_pkg.sv
// Purpose: Types shared by the timer channel modules
// Assumes: Nothing
// Notes: Mode codes follow the mode field encoding
package tmr_pkg;

   typedef enum logic [2:0]
   {
      MD_INTERVAL = 3'h0,
      MD_EVENT = 3'h1,
      MD_EXT_TRIG = 3'h2,
      MD_ONE_SHOT = 3'h3,
      MD_PWM = 3'h4,
      MD_FREE_RUN = 3'h5,
      MD_PULSE_WIDTH = 3'h6,
      MD_PROHIBITED = 3'h7
   } mode_type;

   typedef enum logic [1:0]
   {
      ST_OFF = 2'h0,
      ST_WAIT = 2'h1,
      ST_RUN = 2'h3
   } chan_state_type;

endpackage

// ### shared/edge_if.sv
// Purpose: Qualified edge pulses from a synchronised timer pin
// Assumes: Single clock domain clk_sys
// Notes: One-cycle pulses
`timescale 1ns/10ps
interface edge_if;
   logic rise;
   logic fall;
   modport src (output rise, output fall);
   modport snk (input rise, input fall);
endinterface

// ### verilog/timer_edge_sync.sv
// Purpose: Three-stage pin synchroniser with rise and fall detection
// Assumes: Pin is asynchronous to clk_sys
// Notes: A change counts once stages two and three agree
`timescale 1ns/10ps
module timer_edge_sync
   import tmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic pin_in,
   edge_if.src edges
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic rise_r;
   logic fall_r;
   logic agree;

   assign agree = (s2_r == s3_r);

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accepted level and edge pulses
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end
      else
      begin
         if (agree)
         begin
            lvl_r <= s3_r;
         end
         rise_r <= agree & s3_r & ~lvl_r;
         fall_r <= agree & ~s3_r & lvl_r;
      end
   end

   assign edges.rise = rise_r;
   assign edges.fall = fall_r;

endmodule

// ### verilog/timer_channel.sv
// Purpose: One 16-bit timer/event counter channel with two compare units
// Assumes: clk_sys is the peripheral clock; companion_tick is on clk_sys
// Notes: Run-enable low holds the whole channel in its idle state
`timescale 1ns/10ps
`include "tmr_consts.svh"

////////////////////////////////////////////////////////////////////////////
// Function
// - One 16-bit up-counter fed by a clock tap, external event edges or the companion tick.
// - Counter holds FFFFH while stopped, but reads back as 0000H.
// - Compare 0 write loads hidden buffer; match raises compare interrupt 0.
// - Compare 1 write loads hidden buffer; match raises compare interrupt 1.
// - Hidden buffers unreachable; reset clears buffers and registers.
// - Pin edge detector selects none, rising, falling or both edges.
// - Count source is one of eight clock taps, the event input or the companion tick.
// - Run-enable bit starts the channel; clearing it stops and resets it.
// - Clock-select codes 0 to 7 give divide by 1 up to 128.
// - Stopping clears overflow flag and restores outputs to set levels.
// - Mode field picks one of seven modes; code 7 is prohibited.
// - Software trigger acts only in trigger or one-shot mode; reads 0.
// - External-event enable switches counting to event input edges.
// - Event count mode counts event edges unless tuning mode is set.
// - Tuning mode follows companion timer; matches start conversions, not interrupts.
// - Output level bit 0 starts output high, 1 starts it low.
// - Output disabled holds the pin at the level bit's value.
// - A channel without trigger input starts pulses by software only.
// - Wrap in free-run or width mode sets overflow flag, and interrupt unless tuning mode is set.
// - Compare 0 match toggles enabled timer output 0.
module timer_channel
   import tmr_pkg::*;
#(
   parameter logic has_ext_input = 1'b1
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [`DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`DATA_W-1:0] reg_rdata,
   input wire logic event_trigger_input,
   input wire logic capture_input_1,
   input wire logic companion_tick,
   output logic timer_output_0,
   output logic timer_output_1,
   output logic compare_match_irq_0,
   output logic compare_match_irq_1,
   output logic overflow_irq,
   output logic adc_start_trigger
);

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r, input logic f);
      edge_hit = (sel[0] & r) | (sel[1] & f);
   endfunction

   function automatic logic tap_hit(input logic [2:0] cks,
                                    input logic [`PRE_W-1:0] pre);
      logic [7:0] m;
      m = {1'b0, pre} | ~((8'h01 << cks) - 8'h01);
      tap_hit = &m;
   endfunction

   logic run_r;
   logic [2:0] cks_r;
   logic tune_r;
   logic eee_r;
   mode_type mode_r;
   logic ol1_r;
   logic oe1_r;
   logic ol0_r;
   logic oe0_r;
   logic [3:0] cap_sel_r;
   logic [1:0] ev_sel_r;
   logic [1:0] trg_sel_r;
   logic ccs1_r;
   logic ccs0_r;
   logic ovf_r;
   logic [15:0] ccr0_r;
   logic [15:0] ccr1_r;
   logic [15:0] buf0_r;
   logic [15:0] buf1_r;
   logic [15:0] cnt_r;
   logic cnt_valid_r;
   logic [`PRE_W-1:0] pre_r;
   chan_state_type st_r;
   logic tog0_r;
   logic tog1_r;
   logic [15:0] rd_mux;

   logic wr_ctl0, wr_ctl1, wr_ioc0, wr_ioc1, wr_ioc2, wr_opt0;
   logic wr_ccr0, wr_ccr1, sw_trig, trig_mode, pulse_mode, clr_mode;
   logic ext_src, tick, count_en, trig_go, cap0, cap1, cap0_clr;
   logic cc0_cmp, cc1_cmp, match0, match1, ovf_evt, wrap0;

   edge_if ev0_if();
   edge_if ev1_if();

   timer_edge_sync u_edge0
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin_in(event_trigger_input),
      .edges(ev0_if)
   );

   timer_edge_sync u_edge1
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin_in(capture_input_1),
      .edges(ev1_if)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign wr_ctl0 = reg_wr && (reg_addr == `OFS_CTL0);
   assign wr_ctl1 = reg_wr && (reg_addr == `OFS_CTL1);
   assign wr_ioc0 = reg_wr && (reg_addr == `OFS_IOC0);
   assign wr_ioc1 = reg_wr && (reg_addr == `OFS_IOC1);
   assign wr_ioc2 = reg_wr && (reg_addr == `OFS_IOC2);
   assign wr_opt0 = reg_wr && (reg_addr == `OFS_OPT0);
   assign wr_ccr0 = reg_wr && (reg_addr == `OFS_CCR0);
   assign wr_ccr1 = reg_wr && (reg_addr == `OFS_CCR1);

   // Run enable and clock select
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_r <= 1'b0;
         cks_r <= 3'h0;
      end
      else if (wr_ctl0)
      begin
         run_r <= reg_wdata[`BIT_RUN];
         cks_r <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tune_r <= 1'b0;
         eee_r <= 1'b0;
         mode_r <= MD_INTERVAL;
      end
      else if (wr_ctl1)
      begin
         tune_r <= reg_wdata[`BIT_TUNE];
         eee_r <= reg_wdata[`BIT_EEE];
         mode_r <= mode_type'(reg_wdata[2:0]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {ol1_r, oe1_r, ol0_r, oe0_r} <= 4'h0;
      end
      else if (wr_ioc0)
      begin
         ol1_r <= reg_wdata[`BIT_OL1];
         oe1_r <= reg_wdata[`BIT_OE1];
         ol0_r <= reg_wdata[`BIT_OL0];
         oe0_r <= reg_wdata[`BIT_OE0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cap_sel_r <= 4'h0;
         ev_sel_r <= 2'h0;
         trg_sel_r <= 2'h0;
         {ccs1_r, ccs0_r} <= 2'h0;
      end
      else
      begin
         if (wr_ioc1)
         begin
            cap_sel_r <= reg_wdata[3:0];
         end
         if (wr_ioc2)
         begin
            ev_sel_r <= reg_wdata[3:2];
            trg_sel_r <= reg_wdata[1:0];
         end
         if (wr_opt0)
         begin
            ccs1_r <= reg_wdata[`BIT_CCS1];
            ccs0_r <= reg_wdata[`BIT_CCS0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count source and mode qualifiers
   assign trig_mode = (mode_r == MD_EXT_TRIG) || (mode_r == MD_ONE_SHOT);
   assign pulse_mode = trig_mode || (mode_r == MD_PWM);
   assign clr_mode = (mode_r != MD_FREE_RUN) && (mode_r != MD_PULSE_WIDTH);
   assign ext_src = (mode_r == MD_EVENT) || eee_r;
   assign tick = tune_r ? companion_tick
      : ext_src ? (has_ext_input
         & edge_hit(ev_sel_r, ev0_if.rise, ev0_if.fall))
      : tap_hit(cks_r, pre_r);
   assign count_en = run_r && (st_r == ST_RUN) && tick;

   assign sw_trig = wr_ctl1 && reg_wdata[`BIT_STRG];
   assign trig_go = run_r && trig_mode && !tune_r && (sw_trig
      || (has_ext_input
         && edge_hit(trg_sel_r, ev0_if.rise, ev0_if.fall)));

   assign cap0 = run_r && has_ext_input
      && edge_hit(cap_sel_r[1:0], ev0_if.rise, ev0_if.fall)
      && ((mode_r == MD_PULSE_WIDTH) || ((mode_r == MD_FREE_RUN) && ccs0_r));
   assign cap1 = run_r && has_ext_input
      && edge_hit(cap_sel_r[3:2], ev1_if.rise, ev1_if.fall)
      && ((mode_r == MD_PULSE_WIDTH) || ((mode_r == MD_FREE_RUN) && ccs1_r));
   assign cap0_clr = cap0 && (mode_r == MD_PULSE_WIDTH);

   assign cc0_cmp = clr_mode || ((mode_r == MD_FREE_RUN) && !ccs0_r);
   assign cc1_cmp = clr_mode || ((mode_r == MD_FREE_RUN) && !ccs1_r);
   assign match0 = count_en && cnt_valid_r && cc0_cmp
      && (cnt_r == buf0_r);
   assign match1 = count_en && cnt_valid_r && cc1_cmp
      && (cnt_r == buf1_r);
   assign wrap0 = clr_mode && match0;
   assign ovf_evt = count_en && cnt_valid_r && !clr_mode
      && (cnt_r == `CNT_IDLE);

   // Prescaler for the internal count taps
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pre_r <= '0;
      end
      else if (!run_r)
      begin
         pre_r <= '0;
      end
      else
      begin
         pre_r <= pre_r + `PRE_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel state
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= ST_OFF;
      end
      else if (!run_r)
      begin
         st_r <= ST_OFF;
      end
      else
      begin
         case (st_r)
            ST_OFF:
            begin
               if (trig_mode && !trig_go)
               begin
                  st_r <= ST_WAIT;
               end
               else
               begin
                  st_r <= ST_RUN;
               end
            end
            ST_WAIT:
            begin
               if (trig_go)
               begin
                  st_r <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if ((mode_r == MD_ONE_SHOT) && match0 && !trig_go)
               begin
                  st_r <= ST_WAIT;
               end
            end
            default:
            begin
               st_r <= ST_OFF;
            end
         endcase
      end
   end

   // Counter
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r <= `CNT_IDLE;
         cnt_valid_r <= 1'b0;
      end
      else if (!run_r)
      begin
         cnt_r <= `CNT_IDLE;
         cnt_valid_r <= 1'b0;
      end
      else if (trig_go || cap0_clr)
      begin
         cnt_r <= '0;
         cnt_valid_r <= 1'b1;
      end
      else if (count_en)
      begin
         cnt_valid_r <= 1'b1;
         if (wrap0)
         begin
            cnt_r <= '0;
         end
         else
         begin
            cnt_r <= cnt_r + `CNT_ONE;
         end
      end
   end

   // Overflow flag: hardware set wins over a software clear
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ovf_r <= 1'b0;
      end
      else if (!run_r)
      begin
         ovf_r <= 1'b0;
      end
      else if (ovf_evt)
      begin
         ovf_r <= 1'b1;
      end
      else if (wr_opt0 && !reg_wdata[`BIT_OVF])
      begin
         ovf_r <= 1'b0;
      end
   end

   // Visible compare registers and hidden buffers
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ccr0_r <= `RST_CCR;
         buf0_r <= `RST_CCR;
      end
      else if (cap0)
      begin
         ccr0_r <= cnt_r;
      end
      else if (wr_ccr0)
      begin
         ccr0_r <= reg_wdata;
         buf0_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ccr1_r <= `RST_CCR;
         buf1_r <= `RST_CCR;
      end
      else if (cap1)
      begin
         ccr1_r <= cnt_r;
      end
      else if (wr_ccr1)
      begin
         ccr1_r <= reg_wdata;
         buf1_r <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output toggles and pins
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tog0_r <= 1'b0;
         tog1_r <= 1'b0;
      end
      else if (!run_r)
      begin
         tog0_r <= 1'b0;
         tog1_r <= 1'b0;
      end
      else
      begin
         if (match0 && oe0_r)
         begin
            tog0_r <= ~tog0_r;
         end
         if (pulse_mode)
         begin
            // Active from compare 1 up to the period end
            if (match1)
            begin
               tog1_r <= 1'b1;
            end
            else if (match0 || trig_go)
            begin
               tog1_r <= 1'b0;
            end
         end
         else if (match1 && oe1_r)
         begin
            tog1_r <= ~tog1_r;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         timer_output_0 <= 1'b0;
         timer_output_1 <= 1'b0;
      end
      else
      begin
         timer_output_0 <= oe0_r ? (~ol0_r ^ tog0_r) : ol0_r;
         timer_output_1 <= oe1_r ? (~ol1_r ^ tog1_r) : ol1_r;
      end
   end

   // Event pulses
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         compare_match_irq_0 <= 1'b0;
         compare_match_irq_1 <= 1'b0;
         overflow_irq <= 1'b0;
         adc_start_trigger <= 1'b0;
      end
      else
      begin
         compare_match_irq_0 <= match0 && !tune_r;
         compare_match_irq_1 <= match1 && !tune_r;
         overflow_irq <= ovf_evt && !tune_r;
         adc_start_trigger <= tune_r && (match0 || match1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; buffers have no address
   always_comb
   begin
      rd_mux = '0;
      if (reg_addr == `OFS_CTL0)
      begin
         rd_mux = {8'h00, run_r, 4'h0, cks_r};
      end
      else if (reg_addr == `OFS_CTL1)
      begin
         rd_mux = {8'h00, tune_r, 1'b0, eee_r, 2'h0, mode_r};
      end
      else if (reg_addr == `OFS_IOC0)
      begin
         rd_mux = {12'h000, ol1_r, oe1_r, ol0_r, oe0_r};
      end
      else if (reg_addr == `OFS_IOC1)
      begin
         rd_mux = {12'h000, cap_sel_r};
      end
      else if (reg_addr == `OFS_IOC2)
      begin
         rd_mux = {12'h000, ev_sel_r, trg_sel_r};
      end
      else if (reg_addr == `OFS_OPT0)
      begin
         rd_mux = {10'h000, ccs1_r, ccs0_r, 3'h0, ovf_r};
      end
      else if (reg_addr == `OFS_CCR0)
      begin
         rd_mux = ccr0_r;
      end
      else if (reg_addr == `OFS_CCR1)
      begin
         rd_mux = ccr1_r;
      end
      else if (reg_addr == `OFS_CNT)
      begin
         rd_mux = run_r ? cnt_r : `CNT_IDLE_RD;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= '0;
      end
      else
      begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   idle_count_a: assert property (!run_r |=> cnt_r == 16'hffff)
      else $error("counter not idle while stopped");
   idle_read_a: assert property (
      reg_rd && (reg_addr == `OFS_CNT) && !run_r |=> reg_rdata == 16'h0000)
      else $error("stopped counter read not zero");
   match0_irq_a: assert property (
      run_r && cc0_cmp && count_en && cnt_valid_r && (cnt_r == buf0_r)
      && !tune_r |=> compare_match_irq_0)
      else $error("compare 0 match lost");
   match1_irq_a: assert property (
      $rose(compare_match_irq_1) |-> $past(cnt_r) == $past(buf1_r))
      else $error("compare 1 irq without match");
   run_start_a: assert property (
      wr_ctl0 && reg_wdata[7] |=> run_r ##1 st_r != ST_OFF)
      else $error("run enable did not start channel");
   stop_clear_a: assert property (
      $fell(run_r) |=> !ovf_r && !tog0_r && !tog1_r)
      else $error("stop did not clear overflow and outputs");
   out_static_a: assert property (
      !oe0_r ##1 !oe0_r |-> timer_output_0 == $past(ol0_r))
      else $error("disabled output not static");
   ovf_set_a: assert property (
      ovf_evt |=> ovf_r && overflow_irq == !$past(tune_r))
      else $error("overflow not flagged");
   count_step_a: assert property (
      count_en && !wrap0 && !trig_go && !cap0_clr
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step by one");
   toggle0_a: assert property (
      match0 && oe0_r && run_r ##1 oe0_r && $stable(ol0_r)
      |=> timer_output_0 != $past(timer_output_0))
      else $error("output 0 did not toggle");

endmodule

// ### tb/event_source.sv
// Purpose: Far-side pin model for the event/trigger and capture pins
// Assumes: Pulse phases long enough for the three-stage pin synchroniser
// Notes: Capture pin is held low; gap sets prompt or slow pulse trains
`timescale 1ns/10ps
module event_source
(
   input wire logic clk_sys,
   input wire logic fire,
   input wire logic [3:0] n_pulses,
   input wire logic [3:0] gap,
   output logic pin,
   output logic cap_pin,
   output logic busy
);
   assign cap_pin = 1'b0;
   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge clk_sys);
         if (fire)
         begin
            busy <= 1'b1;
            repeat (n_pulses)
            begin
               repeat (gap) @(posedge clk_sys);
               pin <= 1'b1;
               repeat (gap) @(posedge clk_sys);
               pin <= 1'b0;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

// ### tb/sixteen_bit_timer_event_counter_tb_top.sv
// Purpose: Self-checking bench for one timer channel
// Assumes: Register port answers reads one cycle after the strobe
// Notes: Overflow test runs the full 16-bit range
`timescale 1ns/10ps
`include "tmr_consts.svh"
module sixteen_bit_timer_event_counter_tb_top;
   logic clk_sys, rst_b, reg_wr, reg_rd, fire;
   logic [`ADDR_W-1:0] reg_addr;
   logic [`DATA_W-1:0] reg_wdata, reg_rdata, rd_v;
   logic out0, out1, irq0, irq1, ovf_irq, ev_pin, cap_pin, busy;
   logic adc_trg, tick_in;
   logic [3:0] n_pulses, gap;
   logic [4:0] obs;
   int err_count, n_tests, cyc_count;
   assign obs = {adc_trg, ovf_irq, irq1, irq0, out0};

   timer_channel timer_channel_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_trigger_input(ev_pin),
      .capture_input_1(cap_pin), .companion_tick(tick_in),
      .timer_output_0(out0), .timer_output_1(out1),
      .compare_match_irq_0(irq0), .compare_match_irq_1(irq1),
      .overflow_irq(ovf_irq), .adc_start_trigger(adc_trg));
   event_source event_source_inst (.clk_sys(clk_sys), .fire(fire),
      .n_pulses(n_pulses), .gap(gap), .pin(ev_pin), .cap_pin(cap_pin),
      .busy(busy));

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         err_count++;
      end
   endtask
   task automatic wr(input logic [27:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [27:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask
   task automatic wait_sig(input int sel, input int lim, output int cyc);
      cyc = -1;
      for (int i = 1; i <= lim && cyc < 0; i++)
      begin
         @(posedge clk_sys);
         #1;
         if (obs[sel] === 1'b1)
            cyc = i;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [27:0] ad [10] = '{`OFS_CTL0, `OFS_IOC0, `OFS_IOC1, `OFS_IOC2,
         `OFS_OPT0, `OFS_CCR0, `OFS_CCR1, `OFS_CNT, `OFS_CTL1, 28'hffff641};
      for (int i = 0; i < 10; i++)
      begin
         rd(ad[i]);
         chk("reset value", 16'h0000, rd_v);
      end
      wr(`OFS_CTL0, 16'h0007);
      wr(28'hffff641, 16'h00ff);
      rd(`OFS_CTL0);
      chk("ctl0 readback", 16'h0007, rd_v);
      rd(28'hffff641);
      chk("unmapped", 16'h0000, rd_v);
      wr(`OFS_CTL0, 16'h0000);
      $display("done reset");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 8; m++)
      begin
         wr(`OFS_CTL1, 16'(m));
         rd(`OFS_CTL1);
         chk("mode field", 16'(m), rd_v);
      end
      wr(`OFS_CTL1, 16'h0040);
      rd(`OFS_CTL1);
      chk("trigger bit", 16'h0000, rd_v);
      $display("done modes");
   endtask
   task automatic t_prescale;
      int c;
      wr(`OFS_CCR0, 16'h0001);
      for (int k = 0; k < 8; k++)
      begin
         wr(`OFS_CTL0, 16'(8'h80 | k));
         wait_sig(1, 600, c);
         wait_sig(1, 600, c);
         chk("match period", 16'(2 << k), 16'(c));
         wr(`OFS_CTL0, 16'h0000);
      end
      $display("done prescale");
   endtask
   task automatic t_cmp1;
      int c;
      wr(`OFS_CCR0, 16'h0009);
      wr(`OFS_CCR1, 16'h0004);
      wr(`OFS_CTL0, 16'h0080);
      wait_sig(2, 50, c);
      wait_sig(1, 50, c);
      chk("cc1 to cc0", 16'h0005, 16'(c));
      wr(`OFS_CTL0, 16'h0000);
      $display("done compare 1");
   endtask
   task automatic t_output;
      int c;
      logic [7:0] v [3] = '{8'h0a, 8'h00, 8'h05};
      logic [1:0] e [3] = '{2'b11, 2'b00, 2'b11};
      for (int i = 0; i < 3; i++)
      begin
         wr(`OFS_IOC0, {8'h00, v[i]});
         repeat (2) @(posedge clk_sys);
         #1;
         chk("static out", 16'(e[i]), {14'h0, out1, out0});
      end
      wr(`OFS_CTL0, 16'h0080);
      wait_sig(1, 50, c);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("toggled out0", 16'h0000, 16'(out0));
      wr(`OFS_CTL0, 16'h0000);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("stop level", 16'h0001, 16'(out0));
      wr(`OFS_IOC0, 16'h0000);
      $display("done output");
   endtask
   task automatic t_event;
      logic [7:0] c1 [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h20};
      logic [7:0] e2 [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h0c};
      logic [15:0] ex [5] = '{16'hffff, 16'h1, 16'h1, 16'h3, 16'h3};
      for (int i = 0; i < 5; i++)
      begin
         wr(`OFS_CTL0, 16'h0000);
         wr(`OFS_IOC2, {8'h00, e2[i]});
         wr(`OFS_CTL1, {8'h00, c1[i]});
         wr(`OFS_CTL0, 16'h0080);
         @(posedge clk_sys);
         fire <= 1'b1;
         n_pulses <= 4'h2;
         gap <= 4'(3 + 2 * i);
         @(posedge clk_sys);
         fire <= 1'b0;
         #1;
         for (int j = 0; j < 300 && busy !== 1'b0; j++)
            @(posedge clk_sys);
         repeat (8) @(posedge clk_sys);
         rd(`OFS_CNT);
         chk("event count", ex[i], rd_v);
      end
      $display("done event");
   endtask
   task automatic t_trigger;
      int c;
      wr(`OFS_CCR0, 16'h0003);
      for (int m = 2; m < 4; m++)
      begin
         wr(`OFS_CTL0, 16'h0000);
         wr(`OFS_CTL1, 16'(m));
         wr(`OFS_CTL0, 16'h0080);
         wait_sig(1, 30, c);
         chk("no trigger", 16'hffff, 16'(c));
         wr(`OFS_CTL1, 16'(8'h40 | m));
         wait_sig(1, 40, c);
         chk("sw trigger", 16'h0001, 16'(c > 0));
         rd(`OFS_CTL1);
         chk("trigger read", 16'(m), rd_v);
      end
      wr(`OFS_CTL0, 16'h0000);
      $display("done trigger");
   endtask
   task automatic t_tune;
      int c;
      wr(`OFS_CTL1, 16'h0080);
      tick_in <= 1'b1;
      wr(`OFS_CTL0, 16'h0080);
      wait_sig(4, 30, c);
      chk("adc trigger", 16'h0001, 16'(c > 0));
      wait_sig(1, 8, c);
      chk("irq in tuning", 16'hffff, 16'(c));
      wr(`OFS_CTL0, 16'h0000);
      tick_in <= 1'b0;
      $display("done tuning");
   endtask
   task automatic t_overflow;
      int c;
      wr(`OFS_CTL1, 16'h0005);
      wr(`OFS_CTL0, 16'h0080);
      wait_sig(3, 65600, c);
      chk("overflow irq", 16'h0001, 16'(c > 0));
      rd(`OFS_OPT0);
      chk("overflow flag", 16'h0001, rd_v);
      wr(`OFS_CTL0, 16'h0000);
      rd(`OFS_OPT0);
      chk("flag cleared", 16'h0000, rd_v);
      $display("done overflow");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cyc_count++;
      if (cyc_count == 90000)
      begin
         err_count++;
         report_and_stop;
      end
   end
   initial
   begin
      {rst_b, reg_wr, reg_rd, fire, tick_in} = 5'h00;
      reg_addr = '0;
      reg_wdata = '0;
      n_pulses = 4'h0;
      gap = 4'h0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset;
      t_modes;
      t_prescale;
      t_cmp1;
      t_output;
      t_event;
      t_trigger;
      t_tune;
      t_overflow;
      report_and_stop;
   end
endmodule
